// ### design/ssc_pkg.sv
// Constants for the sleep synchronisation coordinator.
// How it works
// (RL1) Coordinator in deployment mode sends syncs fast until its own relay is heard.
// (RL2) Node out of deployment rejects deploy-mode syncs and sends a corrective.
// (RL3) An option bit disables deployment mode.
// (RL4) Normal coordinator syncs at wake start, resends once if unrelayed.
// (RL5) Never-synced non-coordinator requests sync at each wake start.
// (RL6) Synced node answers a sync request with a sync.
// (RL7) Non-coordinator-only node requests sync after six missed cycles.
// (RL8) Preferred bit makes the node coordinator, syncing every wake.
// (RL9) Self-nomination is off after reset; an option bit enables it.
// (RL10) Enabled node, not non-coordinator, missing three syncs becomes coordinator.
// (RL11) Election order: newer parameters, preferred, support mode, serial.
// (RL12) An option bit removes the support-mode advantage.
// (RL13) Enabled button double press or command nominates the node.
// (RL14) Non-coordinator-only nodes ignore button nomination.
// (RL15) Local sleep or wake change makes coordinator, sent next wake.
// (RL16) Timing uses sync values; two query registers report them.
// (RL17) Network setting changes can also make the node coordinator.
// (RL18) Guard time depends on sleep, wake and missed cycles.
// (RL19) Each further miss lengthens the guard time.
// (RL20) Early wake scales with misses unless an option disables it.
// (RL21) Wake time is raised to its minimum on related changes.
// (RL22) Unrelayed sync resent once; accepted syncs are relayed.
// (RL23) Missed-sync counter clears on sync, advances per silent wake.
package ssc_pkg;
  localparam logic [7:0] ADDR_OPTS = 8'h00;
  localparam logic [7:0] ADDR_SP = 8'h04;
  localparam logic [7:0] ADDR_ST = 8'h08;
  localparam logic [7:0] ADDR_NETCFG = 8'h0C;
  localparam logic [7:0] ADDR_CMD = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_NET_SP = 8'h18;
  localparam logic [7:0] ADDR_NET_ST = 8'h1C;
  localparam logic [7:0] ADDR_GUARD = 8'h20;
  localparam int OPT_PREF = 0;
  localparam int OPT_NO_DEPLOY = 1;
  localparam int OPT_NOMINATE = 2;
  localparam int OPT_NON_COORD = 3;
  localparam int OPT_NO_EARLY = 4;
  localparam int OPT_SUPPORT_EQ = 5;
  localparam int OPT_BUTTON = 6;
  localparam logic [7:0] OPTS_RST = 8'h00;
  localparam logic [15:0] SP_RST = 16'h00C8;
  localparam logic [15:0] ST_RST = 16'h0040;
  localparam logic [31:0] NETCFG_RST = 32'h0000_0307;
  localparam logic [15:0] WAKE_PER_HOP = 16'h0002;
  localparam logic [15:0] WAKE_BASE = 16'h0010;
  localparam int GUARD_SHIFT = 6;
  localparam int EARLY_SHIFT = 5;
  localparam logic [3:0] MISS_NOMINATE = 4'h3;
  localparam logic [3:0] MISS_REQUEST = 4'h6;
  localparam logic [3:0] MISS_MAX = 4'hF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int DEPLOY_GAP_NS = 10000;
  localparam int RELAY_WAIT_NS = 20000;
  localparam int DEPLOY_CYC = DEPLOY_GAP_NS * 1000 / CLK_PERIOD_PS;
  localparam int RELAY_CYC = RELAY_WAIT_NS * 1000 / CLK_PERIOD_PS;

  function automatic logic [31:0] ssc_merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = data[i*8 +: 8];
    end
    return r;
  endfunction : ssc_merge

  function automatic logic [15:0] ssc_min_wake(input logic [31:0] cfg);
    logic [15:0] m;
    m = cfg[7:0] * cfg[15:8];
    return 16'(m * WAKE_PER_HOP + WAKE_BASE);
  endfunction : ssc_min_wake

  function automatic logic [15:0] ssc_scale(input logic [15:0] b,
      input logic [4:0] m);
    return 16'(b * m);
  endfunction : ssc_scale
endpackage : ssc_pkg

// ### design/ssc_elect.sv
// Seniority comparison between this node and a peer coordinator.
`timescale 1ns/1ps
module ssc_elect (
  input wire logic [7:0] own_gen,
  input wire logic own_pref,
  input wire logic own_support,
  input wire logic [31:0] own_serial,
  input wire logic [7:0] peer_gen,
  input wire logic peer_pref,
  input wire logic peer_support,
  input wire logic [31:0] peer_serial,
  input wire logic support_equal,
  output logic peer_senior
);
  always_comb begin
    if (peer_gen != own_gen) begin // RL11
      peer_senior = peer_gen > own_gen;
    end else if (peer_pref != own_pref) begin
      peer_senior = peer_pref;
    end else if (!support_equal && peer_support != own_support) begin // RL12
      peer_senior = peer_support;
    end else begin
      peer_senior = peer_serial > own_serial;
    end
  end
endmodule : ssc_elect

// ### design/ssc_core.sv
// Sleep synchronisation coordinator with AXI4-Lite registers.
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module ssc_core #(
  parameter logic [31:0] SERIAL = 32'h0000_0001
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wake_start,
  input wire logic wake_end,
  input wire logic support_mode,
  input wire logic button_double,
  input wire logic rx_sync,
  input wire logic rx_sync_deploy,
  input wire logic [15:0] rx_sync_sp,
  input wire logic [15:0] rx_sync_st,
  input wire logic [7:0] rx_sync_gen,
  input wire logic rx_sync_pref,
  input wire logic rx_sync_support,
  input wire logic [31:0] rx_sync_serial,
  input wire logic rx_own_relay,
  input wire logic rx_sync_req,
  output logic tx_sync,
  output logic tx_sync_req,
  output logic tx_corrective,
  output logic tx_relay,
  output logic coordinator,
  output logic deploy_mode,
  output logic [7:0] tx_gen,
  output logic [15:0] net_sleep_period,
  output logic [15:0] net_wake_time,
  output logic [15:0] guard_time,
  output logic [15:0] early_wake
);
  typedef struct packed {
    logic awrdy;
    logic wrdy;
    logic arrdy;
    logic aw_got;
    logic w_got;
    logic bvalid;
    logic rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] rdata;
    logic [7:0] opts;
    logic [15:0] sp;
    logic [15:0] st;
    logic [31:0] net_cfg;
    logic [15:0] net_sp;
    logic [15:0] net_st;
    logic [7:0] gen;
    logic coord;
    logic deploy;
    logic dmode;
    logic synced;
    logic got;
    logic relay_wait;
    logic heard;
    logic resent;
    logic pending;
    logic [3:0] missed;
    logic [11:0] cnt;
    logic tx_sync;
    logic tx_req;
    logic tx_corr;
    logic tx_relay;
    logic [15:0] guard;
    logic [15:0] early;
  } ssc_state_t;

  localparam logic [11:0] DEPLOY_LAST = 12'(ssc_pkg::DEPLOY_CYC - 1);
  localparam logic [11:0] RELAY_LAST = 12'(ssc_pkg::RELAY_CYC - 1);

  ssc_state_t s_reg;
  ssc_state_t s_next;
  logic peer_senior;
  logic non_coord;
  logic sp_cfg_wr;
  logic btn_req;
  // A function result cannot be part-selected directly
  logic [31:0] merged;

  ssc_elect u_elect (
    .own_gen(s_reg.gen),
    .own_pref(s_reg.opts[ssc_pkg::OPT_PREF]),
    .own_support(support_mode),
    .own_serial(SERIAL),
    .peer_gen(rx_sync_gen),
    .peer_pref(rx_sync_pref),
    .peer_support(rx_sync_support),
    .peer_serial(rx_sync_serial),
    .support_equal(s_reg.opts[ssc_pkg::OPT_SUPPORT_EQ]),
    .peer_senior(peer_senior)
  );

  always_comb begin
    s_next = s_reg;
    sp_cfg_wr = 1'b0;
    merged = 32'h0000_0000;
    btn_req = button_double;
    non_coord = s_reg.opts[ssc_pkg::OPT_NON_COORD];
    s_next.tx_sync = 1'b0;
    s_next.tx_req = 1'b0;
    s_next.tx_corr = 1'b0;
    s_next.tx_relay = 1'b0;
    // Deployment bursts and the single resend share one counter
    if (s_reg.coord && s_reg.dmode) begin
      if (s_reg.cnt == 12'h000) begin
        s_next.tx_sync = 1'b1; // RL1
        s_next.cnt = DEPLOY_LAST;
      end else begin
        s_next.cnt = s_reg.cnt - 12'h001;
      end
    end else if (s_reg.relay_wait) begin
      if (s_reg.cnt == 12'h000) begin
        s_next.relay_wait = 1'b0;
        if (!s_reg.heard && !s_reg.resent) begin
          s_next.tx_sync = 1'b1; // RL4 RL22
          s_next.resent = 1'b1;
        end
      end else begin
        s_next.cnt = s_reg.cnt - 12'h001;
      end
    end
    if (rx_own_relay && s_reg.coord) begin
      s_next.heard = 1'b1;
      s_next.deploy = 1'b0; // RL1
    end
    if (wake_start) begin
      s_next.got = 1'b0;
      s_next.pending = 1'b0;
      if (s_reg.pending && !non_coord) begin
        s_next.coord = 1'b1; // RL15 RL17
        s_next.net_sp = s_reg.sp;
        s_next.net_st = s_reg.st;
        s_next.gen = s_reg.gen + 8'h01;
        s_next.synced = 1'b1;
      end
      if (s_reg.opts[ssc_pkg::OPT_PREF]) s_next.coord = 1'b1; // RL8
      if (s_next.coord && !s_reg.dmode) begin
        s_next.tx_sync = 1'b1; // RL4 RL8
        s_next.relay_wait = 1'b1;
        s_next.heard = 1'b0;
        s_next.resent = 1'b0;
        s_next.cnt = RELAY_LAST;
      end else if (!s_next.coord) begin
        if (!s_reg.synced) s_next.tx_req = 1'b1; // RL5
        if (non_coord && s_reg.missed >= ssc_pkg::MISS_REQUEST) begin
          s_next.tx_req = 1'b1; // RL7
        end
      end
    end
    if (wake_end) begin
      if (!s_reg.coord && !s_reg.got && s_reg.missed != ssc_pkg::MISS_MAX) begin
        s_next.missed = s_reg.missed + 4'h1; // RL23
      end
      if (s_reg.opts[ssc_pkg::OPT_NOMINATE] && !non_coord &&
          s_reg.missed >= ssc_pkg::MISS_NOMINATE) begin
        s_next.coord = 1'b1; // RL9 RL10
      end
    end
    if (rx_sync) begin
      if (rx_sync_deploy && !s_reg.dmode) begin
        s_next.tx_corr = 1'b1; // RL2
      end else if (!s_reg.coord || (peer_senior &&
                   !s_reg.opts[ssc_pkg::OPT_PREF])) begin
        s_next.coord = 1'b0; // RL11
        s_next.net_sp = rx_sync_sp; // RL16
        s_next.net_st = rx_sync_st;
        s_next.gen = rx_sync_gen;
        s_next.synced = 1'b1;
        s_next.got = 1'b1;
        s_next.missed = 4'h0; // RL23
        s_next.deploy = 1'b0;
        s_next.relay_wait = 1'b0;
        s_next.tx_relay = 1'b1; // RL22
      end
    end
    if (rx_sync_req && s_reg.synced) s_next.tx_sync = 1'b1; // RL6
    // Register bus: address and data may come in either order
    if (s_reg.bvalid && s_axi_bready) s_next.bvalid = 1'b0;
    if (s_axi_awvalid && s_reg.awrdy) begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wrdy) begin
      s_next.w_got = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = ssc_pkg::RESP_OKAY;
      case ({s_reg.aw_addr[7:2], 2'b00})
        ssc_pkg::ADDR_OPTS: begin
          merged = ssc_pkg::ssc_merge(32'(s_reg.opts), s_reg.w_data,
                                      s_reg.w_strb);
          s_next.opts = merged[7:0];
        end
        ssc_pkg::ADDR_SP: begin
          merged = ssc_pkg::ssc_merge(32'(s_reg.sp), s_reg.w_data,
                                      s_reg.w_strb);
          s_next.sp = merged[15:0];
          sp_cfg_wr = 1'b1;
        end
        ssc_pkg::ADDR_ST: begin
          merged = ssc_pkg::ssc_merge(32'(s_reg.st), s_reg.w_data,
                                      s_reg.w_strb);
          s_next.st = merged[15:0];
        end
        ssc_pkg::ADDR_NETCFG: begin
          s_next.net_cfg = ssc_pkg::ssc_merge(s_reg.net_cfg, s_reg.w_data,
                                              s_reg.w_strb);
          sp_cfg_wr = 1'b1;
          s_next.pending = 1'b1; // RL17
        end
        ssc_pkg::ADDR_CMD: begin
          if (s_reg.w_strb[0] && s_reg.w_data[0]) btn_req = 1'b1;
        end
        default: s_next.bresp = ssc_pkg::RESP_SLVERR;
      endcase
    end
    if (sp_cfg_wr && s_next.st < ssc_pkg::ssc_min_wake(s_next.net_cfg)) begin
      s_next.st = ssc_pkg::ssc_min_wake(s_next.net_cfg); // RL21
    end
    if (s_next.sp != s_next.net_sp || s_next.st != s_next.net_st) begin
      if (s_next.sp != s_reg.sp || s_next.st != s_reg.st) begin
        s_next.pending = 1'b1; // RL15
      end
    end
    // Button nomination skips the election only until a senior sync
    if (btn_req && s_reg.opts[ssc_pkg::OPT_BUTTON] && !non_coord) begin
      s_next.coord = 1'b1; // RL13 RL14
    end
    if (s_reg.rvalid && s_axi_rready) s_next.rvalid = 1'b0;
    if (s_axi_arvalid && s_reg.arrdy) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = ssc_pkg::RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        ssc_pkg::ADDR_OPTS: s_next.rdata = 32'(s_reg.opts);
        ssc_pkg::ADDR_SP: s_next.rdata = 32'(s_reg.sp);
        ssc_pkg::ADDR_ST: s_next.rdata = 32'(s_reg.st);
        ssc_pkg::ADDR_NETCFG: s_next.rdata = s_reg.net_cfg;
        ssc_pkg::ADDR_CMD: s_next.rdata = 32'h0000_0000;
        ssc_pkg::ADDR_STATUS: begin
          s_next.rdata = {16'h0000, s_reg.gen, s_reg.missed, s_reg.pending,
                          s_reg.synced, s_reg.dmode, s_reg.coord};
        end
        ssc_pkg::ADDR_NET_SP: s_next.rdata = 32'(s_reg.net_sp); // RL16
        ssc_pkg::ADDR_NET_ST: s_next.rdata = 32'(s_reg.net_st); // RL16
        ssc_pkg::ADDR_GUARD: s_next.rdata = {s_reg.early, s_reg.guard};
        default: begin
          s_next.rdata = 32'h0000_0000;
          s_next.rresp = ssc_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_next.opts[ssc_pkg::OPT_PREF]) s_next.coord = 1'b1; // RL8
    s_next.dmode = s_next.deploy &
                   !s_next.opts[ssc_pkg::OPT_NO_DEPLOY]; // RL3
    s_next.guard = ssc_pkg::ssc_scale(
        (s_next.net_sp >> ssc_pkg::GUARD_SHIFT) +
        (s_next.net_st >> ssc_pkg::GUARD_SHIFT) + 16'h0001,
        {1'b0, s_next.missed} + 5'h01); // RL18 RL19
    s_next.early = s_next.opts[ssc_pkg::OPT_NO_EARLY] ? 16'h0000 :
        ssc_pkg::ssc_scale(s_next.net_sp >> ssc_pkg::EARLY_SHIFT,
                           {1'b0, s_next.missed}); // RL20
    s_next.awrdy = !s_next.aw_got && !s_next.bvalid;
    s_next.wrdy = !s_next.w_got && !s_next.bvalid;
    s_next.arrdy = !s_next.rvalid;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
      s_reg.awrdy <= 1'b1;
      s_reg.wrdy <= 1'b1;
      s_reg.arrdy <= 1'b1;
      s_reg.opts <= ssc_pkg::OPTS_RST; // RL9
      s_reg.sp <= ssc_pkg::SP_RST;
      s_reg.st <= ssc_pkg::ST_RST;
      s_reg.net_sp <= ssc_pkg::SP_RST;
      s_reg.net_st <= ssc_pkg::ST_RST;
      s_reg.net_cfg <= ssc_pkg::NETCFG_RST;
      s_reg.deploy <= 1'b1;
      s_reg.dmode <= 1'b1;
      s_reg.guard <= 16'h0008;
      s_reg.early <= 16'h0000;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready = s_reg.awrdy;
  assign s_axi_wready = s_reg.wrdy;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_arready = s_reg.arrdy;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign s_axi_rvalid = s_reg.rvalid;
  assign tx_sync = s_reg.tx_sync;
  assign tx_sync_req = s_reg.tx_req;
  assign tx_corrective = s_reg.tx_corr;
  assign tx_relay = s_reg.tx_relay;
  assign coordinator = s_reg.coord;
  assign deploy_mode = s_reg.dmode;
  assign tx_gen = s_reg.gen;
  assign net_sleep_period = s_reg.net_sp;
  assign net_wake_time = s_reg.net_st;
  assign guard_time = s_reg.guard;
  assign early_wake = s_reg.early;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  property p_deploy_stop;
    rx_own_relay && coordinator |=> !deploy_mode;
  endproperty
  a_deploy_stop: assert property (p_deploy_stop) // RL1
    else $error("deploy mode kept after own relay");

  property p_corrective;
    rx_sync && rx_sync_deploy && !deploy_mode |=> tx_corrective && !tx_relay;
  endproperty
  a_corrective: assert property (p_corrective) // RL2
    else $error("deploy sync not rejected");

  property p_no_deploy;
    s_reg.opts[ssc_pkg::OPT_NO_DEPLOY] |-> !deploy_mode;
  endproperty
  a_no_deploy: assert property (p_no_deploy) // RL3
    else $error("deploy mode active while disabled");

  property p_resend_once;
    tx_sync && !deploy_mode && coordinator ##0 s_reg.resent |=>
      !tx_sync [*2];
  endproperty
  a_resend_once: assert property (p_resend_once) // RL4
    else $error("sync resent more than once");

  property p_reply;
    rx_sync_req && s_reg.synced |=> tx_sync;
  endproperty
  a_reply: assert property (p_reply) // RL6
    else $error("sync request not answered");

  property p_pref;
    s_reg.opts[ssc_pkg::OPT_PREF] |=> coordinator;
  endproperty
  a_pref: assert property (p_pref) // RL8
    else $error("preferred node not coordinator");

  property p_nominate;
    wake_end && s_reg.opts[ssc_pkg::OPT_NOMINATE] &&
      !s_reg.opts[ssc_pkg::OPT_NON_COORD] &&
      s_reg.missed >= ssc_pkg::MISS_NOMINATE |=> coordinator;
  endproperty
  a_nominate: assert property (p_nominate) // RL10
    else $error("nomination missing");

  property p_non_coord;
    !coordinator && s_reg.opts[ssc_pkg::OPT_NON_COORD] &&
      !s_reg.opts[ssc_pkg::OPT_PREF] |=> !coordinator;
  endproperty
  a_non_coord: assert property (p_non_coord) // RL14
    else $error("non-coordinator node took the role");

  property p_guard_grow;
    s_reg.missed > $past(s_reg.missed) && net_sleep_period ==
      $past(net_sleep_period) |-> guard_time > $past(guard_time);
  endproperty
  a_guard_grow: assert property (p_guard_grow) // RL19
    else $error("guard did not lengthen on miss");
endmodule : ssc_core

// ### verif/ssc_peer_model.sv
// Peer node model: relays our syncs and answers sync requests.
`timescale 1ns/1ps
module ssc_peer_model (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic tx_sync,
  input wire logic tx_sync_req,
  input wire logic relay_on,
  input wire logic inj,
  output logic rx_sync,
  output logic rx_sync_deploy,
  output logic [15:0] rx_sync_sp,
  output logic [15:0] rx_sync_st,
  output logic [7:0] rx_sync_gen,
  output logic rx_own_relay
);
  logic [2:0] hop_reg;
  logic dep_reg;
  // Junk outside the pulse so stale payload cannot pass
  assign rx_sync_deploy = rx_sync ? dep_reg : ~dep_reg;
  assign rx_sync_sp = rx_sync ? 16'h0100 : 16'hFEFF;
  assign rx_sync_st = rx_sync ? 16'h0080 : 16'hFF7F;
  assign rx_sync_gen = rx_sync ? 8'h00 : 8'hFF;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hop_reg <= 3'h0;
      rx_own_relay <= 1'b0;
      rx_sync <= 1'b0;
      dep_reg <= 1'b0;
    end else begin
      // Air time of a few cycles before a neighbour repeats us
      hop_reg <= {hop_reg[1:0], tx_sync & relay_on};
      rx_own_relay <= hop_reg[2];
      rx_sync <= inj | tx_sync_req;
      // Injected syncs pose as a coordinator still deploying
      dep_reg <= inj;
    end
  end
endmodule : ssc_peer_model

// ### verif/tb_sleep_sync_coordinator.sv
// Self-checking bench for the sleep synchronisation coordinator.
`timescale 1ns/1ps
`define CHK(a, e) check(32'(a), 32'(e))
module tb_sleep_sync_coordinator;
  localparam logic [7:0] RA [6] = '{8'h00, 8'h0C, 8'h18, 8'h1C, 8'h10, 8'h24};
  localparam logic [31:0] RV [6] = '{32'h0, 32'h0307, 32'hC8, 32'h40,
      32'h0, 32'h0};
  localparam logic [1:0] RR [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, tx_sync, tx_sync_req, tx_corrective, tx_relay;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [4:0] ev = 5'h00;
  logic relay_on = 1'b0;
  logic coordinator, deploy_mode, rx_sync, rx_sync_deploy, rx_own_relay;
  logic [15:0] rx_sync_sp, rx_sync_st, net_sleep_period, guard_time;
  logic [15:0] early_wake, net_wake_time;
  logic [7:0] rx_sync_gen, tx_gen;
  wire logic [3:0] tx = {tx_relay, tx_corrective, tx_sync_req, tx_sync};
  int cnt[4] = '{default: 0};
  int base[4] = '{default: 0};
  int num_errors = 0;
  int n_tests = 0;

  always #4 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) cnt[i] <= cnt[i] + int'(tx[i]);
  end

  ssc_core dut (
    .core_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .wake_start(ev[0]), .wake_end(ev[1]),
    .support_mode(1'b0), .button_double(ev[2]), .rx_sync, .rx_sync_deploy,
    .rx_sync_sp, .rx_sync_st, .rx_sync_gen, .rx_sync_pref(1'b0),
    .rx_sync_support(1'b0), .rx_sync_serial(32'h0000_0002), .rx_own_relay,
    .rx_sync_req(ev[3]), .tx_sync, .tx_sync_req, .tx_corrective, .tx_relay,
    .coordinator, .deploy_mode, .tx_gen, .net_sleep_period,
    .net_wake_time, .guard_time, .early_wake
  );

  ssc_peer_model peer (
    .core_clk, .arst_n, .tx_sync, .tx_sync_req, .relay_on, .inj(ev[4]),
    .rx_sync, .rx_sync_deploy, .rx_sync_sp, .rx_sync_st, .rx_sync_gen,
    .rx_own_relay
  );

  task automatic conclude;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] a, input logic [31:0] e);
    n_tests++;
    if (a !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, a, e);
    end
  endtask : check

  task automatic hang;
    num_errors++;
    conclude();
  endtask : hang

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  task automatic strobe(input int k);
    @(posedge core_clk);
    ev[k] <= 1'b1;
    @(posedge core_clk);
    ev[k] <= 1'b0;
  endtask : strobe

  task automatic rst;
    arst_n <= 1'b0;
    cyc(5);
    arst_n <= 1'b1;
  endtask : rst

  function automatic int dl(input int i);
    return cnt[i] - base[i];
  endfunction : dl

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask : w

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] r;
    rd(a, v, r);
    `CHK(v, e);
  endtask : rc

  initial begin
    logic [31:0] v;
    logic [1:0] r;
    logic [15:0] g0;
    rst();
    for (int i = 0; i < 6; i++) begin
      rd(RA[i], v, r);
      `CHK(v, RV[i]);
      `CHK(r, RR[i]);
    end
    `CHK(deploy_mode, 1'b1);
    base = cnt;
    strobe(0);
    cyc(6);
    `CHK(dl(1), 1);
    `CHK(dl(3), 1);
    `CHK(deploy_mode, 1'b0);
    `CHK(net_sleep_period, 16'h0100);
    `CHK(net_wake_time, 16'h0080);
    `CHK(tx_gen, 8'h00);
    rc(ssc_pkg::ADDR_SP, 32'h0000_00C8);
    rc(ssc_pkg::ADDR_NET_ST, 32'h0000_0080);
    g0 = guard_time;
    base = cnt;
    strobe(3);
    cyc(3);
    `CHK(dl(0), 1);
    base = cnt;
    strobe(4);
    cyc(4);
    `CHK(dl(2), 1);
    `CHK(dl(3), 0);
    base = cnt;
    for (int m = 1; m <= 6; m++) begin
      strobe(0);
      strobe(1);
      rd(ssc_pkg::ADDR_STATUS, v, r);
      `CHK(v[7:4], m);
      `CHK(guard_time, g0 * (m + 1));
      `CHK(early_wake, (16'h0100 >> 5) * m);
    end
    `CHK(dl(1), 0);
    // Early wake off plus non-coordinator only
    w(ssc_pkg::ADDR_OPTS, 32'h0000_0018);
    cyc(2);
    `CHK(early_wake, 16'h0000);
    base = cnt;
    strobe(0);
    cyc(3);
    `CHK(dl(1), 1);
    w(ssc_pkg::ADDR_OPTS, 32'h0000_0048);
    strobe(2);
    cyc(2);
    `CHK(coordinator, 1'b0);
    w(ssc_pkg::ADDR_OPTS, 32'h0000_0040);
    strobe(2);
    cyc(2);
    `CHK(coordinator, 1'b1);
    base = cnt;
    strobe(0);
    cyc(2600);
    `CHK(dl(0), 2);
    relay_on <= 1'b1;
    base = cnt;
    strobe(0);
    cyc(2600);
    `CHK(dl(0), 1);
    w(ssc_pkg::ADDR_NETCFG, 32'h0000_0808);
    rc(ssc_pkg::ADDR_ST, 32'h0000_0090);
    // Fresh node, button coordinator in deployment mode
    relay_on <= 1'b0;
    rst();
    w(ssc_pkg::ADDR_OPTS, 32'h0000_0040);
    base = cnt;
    strobe(2);
    cyc(2600);
    `CHK(dl(0), 3);
    relay_on <= 1'b1;
    base = cnt;
    cyc(2600);
    `CHK(dl(0), 1);
    `CHK(deploy_mode, 1'b0);
    rst();
    w(ssc_pkg::ADDR_OPTS, 32'h0000_0002);
    w(ssc_pkg::ADDR_SP, 32'h0000_0200);
    `CHK(deploy_mode, 1'b0);
    `CHK(coordinator, 1'b0);
    strobe(0);
    cyc(2);
    `CHK(coordinator, 1'b1);
    `CHK(net_sleep_period, 16'h0200);
    `CHK(net_wake_time, 16'h0040);
    `CHK(tx_gen, 8'h01);
    conclude();
  end
endmodule : tb_sleep_sync_coordinator
